//--- src/fmc_params.svh
// Offsets, field positions, reset values and timing counts of the feature control block
`ifndef FMC_PARAMS_SVH
`define FMC_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FMC_ADDR_W        8
`define FMC_OFS_CTRL      8'h00
`define FMC_OFS_TARGET    8'h04
`define FMC_OFS_STATUS    8'h08

// ----------------------------------------
// Field positions, bit 0 is the MSB
// ----------------------------------------
`define FMC_LSB0(b)       (31 - (b))
`define FMC_BIT_PRESENT   0
`define FMC_BIT_PUSH      5
`define FMC_BIT_ON        6
`define FMC_BIT_AUTO      7
`define FMC_BIT_VAL_FIRST 20
`define FMC_VALUE_W       12

// ----------------------------------------
// Reset values and adjustment constants
// ----------------------------------------
`define FMC_VALUE_RST     12'h800
`define FMC_TARGET_RST    12'h800
`define FMC_VALUE_MAX     12'hFFF
`define FMC_STEP          12'h001
`define FMC_TOL           12'h010
`define FMC_ITER_MAX      12'hFFF
`define FMC_MODES_RST     4'hF

// ----------------------------------------
// Timing
// ----------------------------------------
`define FMC_CLK_PERIOD_NS 5
`define FMC_ADJ_PERIOD_NS 1000
`define FMC_ADJ_CYCLES    (`FMC_ADJ_PERIOD_NS / `FMC_CLK_PERIOD_NS)
`define FMC_CNT_W         8

`endif

//--- src/fmc_pkg.sv
// Types shared by the feature control block
`include "fmc_params.svh"

package fmc_pkg;

    // ----------------------------------------
    // Feature states
    // ----------------------------------------
    typedef enum logic [1:0] {
        FMC_OFF     = 2'b00,
        FMC_AUTO    = 2'b01,
        FMC_MANUAL  = 2'b10,
        FMC_ONESHOT = 2'b11
    } fmc_state_t;

    // ----------------------------------------
    // Feature drive toward the controlled unit
    // ----------------------------------------
    typedef struct packed {
        logic                      enabled;
        logic                      adjusting;
        logic [`FMC_VALUE_W-1:0]   level;
    } fmc_feat_t;

endpackage

//--- src/fmc_adjust.sv
// Stepwise automatic adjustment engine for one feature value
`timescale 1ns/1ps
`default_nettype none
`include "fmc_params.svh"

module fmc_adjust (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Control
    input  wire logic                    run,
    input  wire logic [`FMC_VALUE_W-1:0] curVal,
    input  wire logic [`FMC_VALUE_W-1:0] measLevel,
    input  wire logic [`FMC_VALUE_W-1:0] target,
    // Result
    output logic                         stepOut,
    output logic [`FMC_VALUE_W-1:0]      nextVal,
    output logic                         inBand
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [`FMC_CNT_W-1:0]   cnt;
        logic                    step;
        logic [`FMC_VALUE_W-1:0] val;
        logic                    band;
    } fmc_adj_t;

    fmc_adj_t st_q;
    fmc_adj_t st_d;

    // Guarded bounds, so the band never wraps at the ends
    logic [`FMC_VALUE_W-1:0] lowBound;
    logic [`FMC_VALUE_W-1:0] highBound;

    assign lowBound  = (target > `FMC_TOL) ? target - `FMC_TOL : '0;
    assign highBound = (target < `FMC_VALUE_MAX - `FMC_TOL) ? target + `FMC_TOL : `FMC_VALUE_MAX;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d      = st_q;
        st_d.step = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt == `FMC_CNT_W'(`FMC_ADJ_CYCLES - 1)) begin
            // One step per period keeps the loop slow and stable
            st_d.cnt  = '0;
            st_d.step = 1'b1;
            st_d.val  = curVal;
            st_d.band = 1'b1;
            if (measLevel < lowBound) begin
                st_d.band = 1'b0;
                if (curVal != `FMC_VALUE_MAX) begin
                    st_d.val = curVal + `FMC_STEP;
                end
            end else if (measLevel > highBound) begin
                st_d.band = 1'b0;
                if (curVal != '0) begin
                    st_d.val = curVal - `FMC_STEP;
                end
            end
        end else begin
            st_d.cnt = st_q.cnt + `FMC_CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign stepOut = st_q.step;
    assign nextVal = st_q.val;
    assign inBand  = st_q.band;

endmodule

`default_nettype wire

//--- src/fmc_csr.sv
// Feature mode control register bank on an AHB-Lite slave
//
// Function
// - Registers are 32 bits wide; bit 0 names the most significant bit.
// - Three mode bits, enable, single shot and auto select, pick one of four states.
// - Enable at zero holds the feature off with a fixed, unadjustable value.
// - Enable and auto select at one give continuous automatic adjustment.
// - Enable one, auto zero, single shot zero: manual, host value applied.
// - Single shot adjusts once, clears itself, returns to manual with adjusted value; the code steps each period until in band or the iteration limit.
// - Value field is valid for control only when the presence flag reads one.
// - Host writes the value only in manual state; elsewhere it is read only.
// - With presence set, reads return the live setting, automatic ones included.
// - A feature may support only some of the four states.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fmc_params.svh"

module fmc_csr #(
    parameter bit       FEATURE_PRESENT = 1'b1,
    parameter bit [3:0] SUPPORTED_MODES = `FMC_MODES_RST
) (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    // Feature side
    input  wire logic [`FMC_VALUE_W-1:0] measLevel,
    output fmc_pkg::fmc_feat_t           featOut,
    output fmc_pkg::fmc_state_t          featState
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic                     on;
        logic                     autoSel;
        logic                     push;
        logic [`FMC_VALUE_W-1:0]  val;
        logic [`FMC_VALUE_W-1:0]  tgt;
        logic [`FMC_VALUE_W-1:0]  iter;
        logic                     settled;
        logic [`FMC_ADDR_W-1:0]   addr;
        logic                     wrPend;
        logic                     rdPend;
        logic                     ready;
        logic [31:0]              rdata;
        logic                     resp;
        fmc_pkg::fmc_state_t      state;
        fmc_pkg::fmc_feat_t       feat;
    } fmc_csr_t;

    fmc_csr_t st_q;
    fmc_csr_t st_d;

    logic                    adjRun;
    logic                    adjStep;
    logic [`FMC_VALUE_W-1:0] adjVal;
    logic                    adjBand;
    logic                    addrTaken;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    function automatic fmc_pkg::fmc_state_t modeOf(input logic on, input logic autoSel,
                                                   input logic push);
        fmc_pkg::fmc_state_t s;
        unique casez ({on, autoSel, push})
            3'b0??: begin
                s = fmc_pkg::FMC_OFF;
            end
            3'b11?: begin
                s = fmc_pkg::FMC_AUTO;
            end
            3'b101: begin
                s = fmc_pkg::FMC_ONESHOT;
            end
            3'b100: begin
                s = fmc_pkg::FMC_MANUAL;
            end
        endcase
        return s;
    endfunction

    // ----------------------------------------
    // Control word image
    // ----------------------------------------
    function automatic logic [31:0] ctrlWord(input fmc_csr_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        // Bit numbering counts from the MSB downward
        w[`FMC_LSB0(`FMC_BIT_PRESENT)] = FEATURE_PRESENT;
        w[`FMC_LSB0(`FMC_BIT_PUSH)]    = s.push;
        w[`FMC_LSB0(`FMC_BIT_ON)]      = s.on;
        w[`FMC_LSB0(`FMC_BIT_AUTO)]    = s.autoSel;
        if (FEATURE_PRESENT) begin
            w[`FMC_LSB0(`FMC_BIT_VAL_FIRST):0] = s.val;
        end
        return w;
    endfunction

    // ----------------------------------------
    // Status word image
    // ----------------------------------------
    // Engine activity is shown so software can see a pending adjustment
    function automatic logic [31:0] statusWord(input fmc_csr_t s, input logic run);
        logic [31:0] w;
        w      = 32'h0000_0000;
        w[3]   = s.settled;
        w[2]   = run;
        w[1:0] = s.state;
        return w;
    endfunction

    // ----------------------------------------
    // Read data image
    // ----------------------------------------
    // Unmapped offsets read zero instead of raising an error
    function automatic logic [31:0] readWord(input fmc_csr_t s, input logic run);
        logic [31:0] w;
        unique case (s.addr)
            `FMC_OFS_CTRL: begin
                w = ctrlWord(s);
            end
            `FMC_OFS_TARGET: begin
                w = {20'h00000, s.tgt};
            end
            `FMC_OFS_STATUS: begin
                w = statusWord(s, run);
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    // ----------------------------------------
    // Mode bits of a written control word
    // ----------------------------------------
    // All other bits of the word are ignored
    function automatic logic [2:0] ctrlBits(input logic [31:0] d);
        logic [2:0] b;
        b[2] = d[`FMC_LSB0(`FMC_BIT_ON)];
        b[1] = d[`FMC_LSB0(`FMC_BIT_AUTO)];
        b[0] = d[`FMC_LSB0(`FMC_BIT_PUSH)];
        return b;
    endfunction

    // ----------------------------------------
    // Value field write permission
    // ----------------------------------------
    // Both the current and the written mode must be manual
    function automatic logic valueOpen(input fmc_pkg::fmc_state_t cur,
                                       input fmc_pkg::fmc_state_t nxt);
        return FEATURE_PRESENT && cur == fmc_pkg::FMC_MANUAL &&
               nxt == fmc_pkg::FMC_MANUAL;
    endfunction

    // ----------------------------------------
    // Adjustment engine
    // ----------------------------------------
    assign adjRun = FEATURE_PRESENT && (st_q.state == fmc_pkg::FMC_AUTO ||
                                        st_q.state == fmc_pkg::FMC_ONESHOT);

    fmc_adjust u_adjust (
        .core_clk  (core_clk),
        .rst       (rst),
        .run       (adjRun),
        .curVal    (st_q.val),
        .measLevel (measLevel),
        .target    (st_q.tgt),
        .stepOut   (adjStep),
        .nextVal   (adjVal),
        .inBand    (adjBand)
    );

    assign addrTaken = hsel && hready && htrans[1];

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        fmc_pkg::fmc_state_t newMode;
        logic                wOn;
        logic                wAuto;
        logic                wPush;
        newMode = fmc_pkg::FMC_OFF;
        wOn     = 1'b0;
        wAuto   = 1'b0;
        wPush   = 1'b0;
        st_d    = st_q;
        // Errors are never signalled, every access completes OKAY
        st_d.resp = 1'b0;

        // Hardware side of the adjustment first, so a host write below wins
        if (adjRun && adjStep) begin
            st_d.val     = adjVal;
            st_d.settled = adjBand;
            if (st_q.state == fmc_pkg::FMC_ONESHOT) begin
                st_d.iter = st_q.iter + `FMC_VALUE_W'(1);
                // Give up after the limit so a stuck loop cannot pin the bit
                if (adjBand || st_q.iter == `FMC_ITER_MAX) begin
                    st_d.push = 1'b0;
                    st_d.iter = '0;
                end
            end
        end

        // Write data phase
        if (st_q.wrPend) begin
            if (st_q.addr == `FMC_OFS_CTRL) begin
                {wOn, wAuto, wPush} = ctrlBits(hwdata);
                newMode = modeOf(wOn, wAuto, wPush);
                // Unsupported combinations leave the mode untouched
                if (SUPPORTED_MODES[newMode]) begin
                    st_d.on      = wOn;
                    st_d.autoSel = wAuto;
                    st_d.push    = wPush;
                    st_d.iter    = '0;
                    if (newMode != fmc_pkg::FMC_ONESHOT) begin
                        st_d.push = 1'b0;
                    end
                end
                if (valueOpen(st_q.state, newMode)) begin
                    st_d.val = hwdata[`FMC_LSB0(`FMC_BIT_VAL_FIRST):0];
                end
            end else if (st_q.addr == `FMC_OFS_TARGET) begin
                st_d.tgt = hwdata[`FMC_VALUE_W-1:0];
            end
            st_d.wrPend = 1'b0;
        end

        // Read data phase: one wait cycle so a preceding write is visible
        if (st_q.rdPend) begin
            st_d.rdata = readWord(st_q, adjRun);
            st_d.rdPend = 1'b0;
            st_d.ready  = 1'b1;
        end

        // Address phase
        if (addrTaken) begin
            st_d.addr   = haddr[`FMC_ADDR_W-1:0];
            st_d.wrPend = hwrite;
            st_d.rdPend = !hwrite;
            st_d.ready  = hwrite;
        end

        // State and drive follow the committed mode bits
        st_d.state = modeOf(st_d.on, st_d.autoSel, st_d.push);
        st_d.feat.enabled   = FEATURE_PRESENT && st_d.on;
        st_d.feat.adjusting = FEATURE_PRESENT && (st_d.state == fmc_pkg::FMC_AUTO ||
                                                  st_d.state == fmc_pkg::FMC_ONESHOT);
        // Off keeps the last value frozen; nothing above can change it then
        st_d.feat.level     = FEATURE_PRESENT ? st_d.val : '0;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q.on       <= 1'b0;
            st_q.autoSel  <= 1'b0;
            st_q.push     <= 1'b0;
            st_q.val      <= `FMC_VALUE_RST;
            st_q.tgt      <= `FMC_TARGET_RST;
            st_q.iter     <= '0;
            st_q.settled  <= 1'b0;
            st_q.addr     <= '0;
            st_q.wrPend   <= 1'b0;
            st_q.rdPend   <= 1'b0;
            st_q.ready    <= 1'b1;
            st_q.rdata    <= 32'h0000_0000;
            st_q.resp     <= 1'b0;
            st_q.state    <= fmc_pkg::FMC_OFF;
            st_q.feat.enabled   <= 1'b0;
            st_q.feat.adjusting <= 1'b0;
            st_q.feat.level     <= FEATURE_PRESENT ? `FMC_VALUE_RST : `FMC_VALUE_W'(0);
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hreadyout = st_q.ready;
    assign hresp     = st_q.resp;
    assign hrdata    = st_q.rdata;
    assign featOut   = st_q.feat;
    assign featState = st_q.state;

endmodule

`default_nettype wire

//--- test/fmc_csr_properties.sv
// Assertion checker for the feature mode control register bank
`timescale 1ns/1ps
`default_nettype none
`include "fmc_params.svh"

module fmc_csr_properties (
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                rst,
    // Bus
    input wire logic                hsel,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic                hready,
    input wire logic                hreadyout,
    // Feature side
    input wire fmc_pkg::fmc_feat_t  featOut,
    input wire fmc_pkg::fmc_state_t featState
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic tk;
    logic wrQ;
    assign tk = hsel & hready & htrans[1];
    // Write data phase marker, manual level may move only after it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) wrQ <= 1'b0;
        else if (hready) wrQ <= tk & hwrite;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_READ_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase length wrong");
    AST_WRITE_NOWAIT: assert property (tk && hwrite |=> hreadyout)
        else $error("write stalled");
    AST_OFF_QUIET: assert property (featState == fmc_pkg::FMC_OFF |-> !featOut.enabled && !featOut.adjusting)
        else $error("off state drives feature");
    AST_OFF_FROZEN: assert property (featState == fmc_pkg::FMC_OFF && $past(featState) == fmc_pkg::FMC_OFF
        |-> $stable(featOut.level))
        else $error("off level moved");
    AST_AUTO_RUNS: assert property (featState == fmc_pkg::FMC_AUTO |-> featOut.adjusting && featOut.enabled)
        else $error("auto not adjusting");
    AST_AUTO_STEP: assert property (featState == fmc_pkg::FMC_AUTO && $past(featState) == fmc_pkg::FMC_AUTO
        && $changed(featOut.level) |-> featOut.level == $past(featOut.level) + 12'h001
        || featOut.level == $past(featOut.level) - 12'h001)
        else $error("auto step not one");
    AST_MANUAL_HELD: assert property (featState == fmc_pkg::FMC_MANUAL && $past(featState) == fmc_pkg::FMC_MANUAL
        && !$past(wrQ) |-> $stable(featOut.level))
        else $error("manual level moved without write");
    AST_SHOT_BACK: assert property ($past(featState) == fmc_pkg::FMC_ONESHOT && featState != fmc_pkg::FMC_ONESHOT
        && !$past(wrQ) |-> featState == fmc_pkg::FMC_MANUAL)
        else $error("single shot did not return to manual");
    AST_SHOT_ADJ: assert property (featState == fmc_pkg::FMC_ONESHOT |-> featOut.adjusting)
        else $error("single shot not adjusting");
endmodule

`default_nettype wire

//--- test/fmc_csr_test.sv
// Self-checking bench for the feature mode control register bank
`timescale 1ns/1ps
`default_nettype none
`include "fmc_params.svh"
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", nm, ex, got); end end

module fmc_csr_test;
    typedef struct packed {
        logic                on;
        logic                au;
        logic                pu;
        logic [11:0]         val;
        logic [11:0]         expVal;
        fmc_pkg::fmc_state_t st;
    } fmc_row_t;

    logic                core_clk;
    logic                rst;
    logic                hsel;
    logic                hwrite;
    logic                hready;
    logic                hreadyout;
    logic                hresp;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr;
    logic [31:0]         hwdata;
    logic [31:0]         hrdata;
    logic [31:0]         rdat;
    logic [11:0]         measLevel;
    fmc_pkg::fmc_feat_t  featOut;
    fmc_pkg::fmc_state_t featState;
    logic                minReadyOut;
    logic                minResp;
    logic [31:0]         minRdata;
    fmc_pkg::fmc_feat_t  minFeat;
    fmc_pkg::fmc_state_t minState;
    int                  fails;
    int                  n_tests;
    fmc_row_t            rows [7];

    assign hready = hreadyout;

    fmc_csr i_fmc_csr (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .measLevel(measLevel), .featOut(featOut), .featState(featState)
    );

    // Variant without value field, only off and manual supported
    fmc_csr #(.FEATURE_PRESENT(1'b0), .SUPPORTED_MODES(4'h5)) i_fmc_csr_min (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(minReadyOut), .hresp(minResp), .hrdata(minRdata),
        .measLevel(measLevel), .featOut(minFeat), .featState(minState)
    );

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    function automatic logic [31:0] cw(logic on, logic au, logic pu, logic [11:0] v);
        cw = 32'h00000000;
        cw[`FMC_LSB0(`FMC_BIT_PRESENT)] = 1'b1;
        cw[`FMC_LSB0(`FMC_BIT_ON)] = on;
        cw[`FMC_LSB0(`FMC_BIT_AUTO)] = au;
        cw[`FMC_LSB0(`FMC_BIT_PUSH)] = pu;
        cw[11:0] = v;
    endfunction

    // Waits are bounded so a dead slave cannot hang the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h000000, a};
        k = 0;
        do begin @(posedge core_clk); k++; end while (hready !== 1'b1 && k < 20);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge core_clk); k++; end while (hready !== 1'b1 && k < 40);
        if (k >= 40) begin
            fails++;
            $display("ERROR bus exp ready got stall");
        end
        rdat = hrdata;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        xfer(1'b0, a, 32'h00000000);
        `CHK(nm, ex, rdat)
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        #(5 * 5000);
        fails++;
        $display("ERROR watchdog exp done got timeout");
        summarize;
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'b00;
        hsize = 3'h2;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        measLevel = 12'h000;
        fails = 0;
        n_tests = 0;
        // Value write only lands when already manual
        rows = '{'{1'b1, 1'b0, 1'b0, 12'h123, 12'h800, fmc_pkg::FMC_MANUAL},
                 '{1'b1, 1'b0, 1'b0, 12'h123, 12'h123, fmc_pkg::FMC_MANUAL},
                 '{1'b0, 1'b0, 1'b0, 12'h456, 12'h123, fmc_pkg::FMC_OFF},
                 '{1'b1, 1'b1, 1'b1, 12'h999, 12'h123, fmc_pkg::FMC_AUTO},
                 '{1'b0, 1'b1, 1'b0, 12'h777, 12'h123, fmc_pkg::FMC_OFF},
                 '{1'b1, 1'b0, 1'b0, 12'h3C5, 12'h123, fmc_pkg::FMC_MANUAL},
                 '{1'b1, 1'b0, 1'b0, 12'h3C5, 12'h3C5, fmc_pkg::FMC_MANUAL}};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("state", fmc_pkg::FMC_OFF, featState)
        `CHK("level", 12'h800, featOut.level)
        rdchk("ctrl", `FMC_OFS_CTRL, cw(1'b0, 1'b0, 1'b0, 12'h800));
        $display("reset test done");

        foreach (rows[i]) begin
            xfer(1'b1, `FMC_OFS_CTRL, cw(rows[i].on, rows[i].au, rows[i].pu, rows[i].val));
            #1;
            `CHK("state", rows[i].st, featState)
            `CHK("level", rows[i].expVal, featOut.level)
            rdchk("ctrl", `FMC_OFS_CTRL, cw(rows[i].on, rows[i].au, 1'b0, rows[i].expVal));
        end
        $display("mode table done");

        xfer(1'b1, `FMC_OFS_CTRL, cw(1'b1, 1'b1, 1'b0, 12'h000));
        repeat (205) @(posedge core_clk);
        #1;
        `CHK("level", 12'h3C6, featOut.level)
        `CHK("adjusting", 1'b1, featOut.adjusting)
        `CHK("minState", fmc_pkg::FMC_MANUAL, minState)
        `CHK("minFeat", 14'h0000, minFeat)
        rdchk("ctrl", `FMC_OFS_CTRL, cw(1'b1, 1'b1, 1'b0, 12'h3C6));
        `CHK("minCtrl", 32'h02000000, minRdata)
        rdchk("status", `FMC_OFS_STATUS, 32'h00000005);
        $display("auto test done");

        xfer(1'b1, `FMC_OFS_CTRL, cw(1'b1, 1'b0, 1'b1, 12'h000));
        #1;
        `CHK("state", fmc_pkg::FMC_ONESHOT, featState)
        `CHK("minState", fmc_pkg::FMC_MANUAL, minState)
        rdchk("ctrl", `FMC_OFS_CTRL, cw(1'b1, 1'b0, 1'b1, 12'h3C6));
        repeat (205) @(posedge core_clk);
        rdchk("ctrl", `FMC_OFS_CTRL, cw(1'b1, 1'b0, 1'b1, 12'h3C7));
        measLevel <= 12'h800;
        repeat (200) @(posedge core_clk);
        #1;
        `CHK("state", fmc_pkg::FMC_MANUAL, featState)
        rdchk("ctrl", `FMC_OFS_CTRL, cw(1'b1, 1'b0, 1'b0, 12'h3C7));
        rdchk("status", `FMC_OFS_STATUS, 32'h0000000A);
        $display("single shot test done");

        xfer(1'b1, `FMC_OFS_TARGET, 32'h00000ABC);
        rdchk("target", `FMC_OFS_TARGET, 32'h00000ABC);
        xfer(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h0C, 32'h00000000);
        `CHK("resp", 1'b0, hresp)
        `CHK("minResp", 1'b0, minResp)
        $display("map test done");

        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("state", fmc_pkg::FMC_OFF, featState)
        `CHK("level", 12'h800, featOut.level)
        rdchk("target", `FMC_OFS_TARGET, 32'h00000800);
        $display("mid-run reset test done");
        summarize;
    end
endmodule

bind fmc_csr fmc_csr_properties i_fmc_csr_properties (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .featOut(featOut), .featState(featState)
);

`default_nettype wire
